/* core/pwm_timer_pair.sv */
// pair of 8-bit pwm timers, cascadable to a 16-bit interval timer, wishbone slave
// Summary of operation
// - 8-bit pwm counter runs on selected source
// - duty match toggles flip-flop, counter continues
// - overflow toggles again, clears counter, raises irq
// - init bit presets flip-flop for pulse polarity
// - reset clears each toggle flip-flop to zero
// - pin is inverse of toggle flip-flop
// - running duty write waits for match irq
// - stopped duty write loads active compare immediately
// - duty read shows value in effect while running, held value when stopped
// - stopping holds pin at its level
// - run bit 3, init bit 7, clear drives high
// - pwm offers seven source clock choices
// - cascade both channels into 16-bit counter
// - 16-bit period match raises upper irq, clears
// - period register acts immediately, unbuffered
// - 16-bit timer offers only four sources
// - cascade clock from lower clock select field
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
module pwm_timer_pair (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [7:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatIn,
	output logic [31:0] wbDatOut,
	output logic wbAck,
	input wire logic subClkIn,
	output logic pwmOutLowN,
	output logic pwmOutHighN,
	output logic lowMatchIrq,
	output logic upperMatchIrq
);

	// ****************************************
	// selection helpers
	// ****************************************
	function automatic logic tickFor(input logic [7:0] taps, input logic [2:0] sel);
		tickFor = taps[sel];
	endfunction

	// 16-bit timer accepts only prescaled taps 0 to 3
	function automatic logic tick16For(input logic [7:0] taps, input logic [2:0] sel);
		tick16For = ~sel[2] & taps[sel];
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [7:0] ctrl_reg [2];
	logic [7:0] dutyHold_reg [2];
	logic [7:0] dutyAct_reg [2];
	logic [7:0] cnt_reg [2];
	logic ff_reg [2];
	logic pinN_reg [2];
	logic runPrev_reg [2];
	logic irq_reg [2];
	logic [7:0] periodLow_reg;
	logic [7:0] periodHigh_reg;
	logic [1:0] config_reg;
	logic ack_reg;
	logic [31:0] rdat_reg;

	wire logic [7:0] taps;
	wire logic busReq;
	wire logic busWrite;
	wire logic [7:0] wdat;
	wire logic cascade;
	wire logic [15:0] cnt16;
	wire logic [15:0] inc16;
	wire logic [15:0] period16;
	wire logic t16Start;
	wire logic t16Step;
	wire logic t16Match;
	wire logic [15:0] cnt16Next;
	wire logic [7:0] readByte;
	wire logic ctrlWr [2];
	wire logic dutyWr [2];
	wire logic running [2];
	wire logic pwmMode [2];
	wire logic pwmStart [2];
	wire logic pwmStep [2];
	wire logic ovf [2];
	wire logic dutyHit [2];
	wire logic ffNext [2];
	wire logic [7:0] inc [2];
	wire logic [7:0] cntNext [2];
	wire logic [7:0] dutyActNext [2];
	wire logic [7:0] dutyRead [2];

	timer_prescaler prescaler (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.subClkIn(subClkIn),
		.prescalerSourceSelect(config_reg[pwm_timer_pkg::CONFIG_PRESCALE_BIT]),
		.slowMode(config_reg[pwm_timer_pkg::CONFIG_SLOW_BIT]),
		.tapTick(taps)
	);

	// ****************************************
	// wishbone slave
	// ****************************************
	// writes land on the edge at which the master sees ack
	assign busReq = wbCyc & wbStb;
	assign busWrite = busReq & wbWe & ack_reg & wbSel[0];
	assign wdat = wbDatIn[7:0];

	assign readByte =
		(wbAdr == pwm_timer_pkg::OFF_CTRL_LOW) ? ctrl_reg[0] :
		(wbAdr == pwm_timer_pkg::OFF_CTRL_HIGH) ? ctrl_reg[1] :
		(wbAdr == pwm_timer_pkg::OFF_DUTY_LOW) ? dutyRead[0] :
		(wbAdr == pwm_timer_pkg::OFF_DUTY_HIGH) ? dutyRead[1] :
		(wbAdr == pwm_timer_pkg::OFF_PERIOD_LOW) ? periodLow_reg :
		(wbAdr == pwm_timer_pkg::OFF_PERIOD_HIGH) ? periodHigh_reg :
		(wbAdr == pwm_timer_pkg::OFF_CONFIG) ? {6'h00, config_reg} :
		8'h00;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h00000000;
		end else begin
			ack_reg <= busReq & ~ack_reg;
			if (wbAdr == pwm_timer_pkg::OFF_COUNT) begin
				rdat_reg <= {16'h0000, cnt16};
			end else begin
				rdat_reg <= {24'h000000, readByte};
			end
		end
	end

	assign wbAck = ack_reg;
	assign wbDatOut = rdat_reg;

	// ****************************************
	// shared registers
	// ****************************************
	// period is not double buffered, so it acts at once; software writes it
	// low byte first and leaves it alone while the timer runs
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			periodLow_reg <= pwm_timer_pkg::PERIOD_RESET;
			periodHigh_reg <= pwm_timer_pkg::PERIOD_RESET;
			config_reg <= 2'h0;
		end else begin
			if (busWrite && wbAdr == pwm_timer_pkg::OFF_PERIOD_LOW) begin
				periodLow_reg <= wdat;
			end
			if (busWrite && wbAdr == pwm_timer_pkg::OFF_PERIOD_HIGH) begin
				periodHigh_reg <= wdat;
			end
			if (busWrite && wbAdr == pwm_timer_pkg::OFF_CONFIG) begin
				config_reg <= wdat[1:0];
			end
		end
	end

	// ****************************************
	// 16-bit cascade
	// ****************************************
	assign cascade = (ctrl_reg[0][2:0] == pwm_timer_pkg::MODE_T16_LOW) &&
		(ctrl_reg[1][2:0] == pwm_timer_pkg::MODE_T16_HIGH);
	assign cnt16 = {cnt_reg[1], cnt_reg[0]};
	assign inc16 = cnt16 + 16'h0001;
	assign period16 = {periodHigh_reg, periodLow_reg};
	assign t16Start = cascade & running[1] & ~runPrev_reg[1];
	assign t16Step = cascade & running[1] & runPrev_reg[1] &
		tick16For(taps, ctrl_reg[0][6:4]);
	assign t16Match = t16Step & (inc16 == period16);
	assign cnt16Next = (t16Start | t16Match) ? 16'h0000 :
		t16Step ? inc16 : cnt16;

	// ****************************************
	// channels
	// ****************************************
	for (genvar j = 0; j < 2; j++) begin : gChan
		logic [7:0] ctrlAdr;
		logic [7:0] dutyAdr;
		assign ctrlAdr = (j == 0) ? pwm_timer_pkg::OFF_CTRL_LOW : pwm_timer_pkg::OFF_CTRL_HIGH;
		assign dutyAdr = (j == 0) ? pwm_timer_pkg::OFF_DUTY_LOW : pwm_timer_pkg::OFF_DUTY_HIGH;

		assign ctrlWr[j] = busWrite & (wbAdr == ctrlAdr);
		assign dutyWr[j] = busWrite & (wbAdr == dutyAdr);
		assign running[j] = ctrl_reg[j][pwm_timer_pkg::CTRL_RUN_BIT];
		assign pwmMode[j] = ~cascade & (ctrl_reg[j][2:0] == pwm_timer_pkg::MODE_PWM8);
		assign pwmStart[j] = pwmMode[j] & running[j] & ~runPrev_reg[j];
		assign pwmStep[j] = pwmMode[j] & running[j] & runPrev_reg[j] &
			tickFor(taps, ctrl_reg[j][6:4]);
		assign inc[j] = cnt_reg[j] + 8'h01;
		assign ovf[j] = pwmStep[j] & (cnt_reg[j] == pwm_timer_pkg::COUNT_MAX);
		assign dutyHit[j] = pwmStep[j] & (inc[j] == dutyAct_reg[j]);
		// a stopped channel takes its flip-flop from the init bit on a control
		// write; the stopping write itself must not carry a new init bit
		assign ffNext[j] = (ctrlWr[j] & ~running[j]) ? wdat[pwm_timer_pkg::CTRL_INIT_BIT] :
			ff_reg[j] ^ dutyHit[j] ^ ovf[j];
		assign cntNext[j] = cascade ? cnt16Next[8*j +: 8] :
			(pwmStart[j] | ovf[j]) ? 8'h00 :
			pwmStep[j] ? inc[j] : cnt_reg[j];
		// a write in the overflow cycle still hands over the old held value
		assign dutyActNext[j] = ovf[j] ? dutyHold_reg[j] :
			(dutyWr[j] & ~running[j]) ? wdat : dutyAct_reg[j];
		assign dutyRead[j] = running[j] ? dutyAct_reg[j] : dutyHold_reg[j];

		always_ff @(posedge core_clk) begin
			if (!rst_n) begin
				ctrl_reg[j] <= pwm_timer_pkg::CTRL_RESET;
				dutyHold_reg[j] <= pwm_timer_pkg::DUTY_RESET;
				dutyAct_reg[j] <= pwm_timer_pkg::DUTY_RESET;
				cnt_reg[j] <= 8'h00;
				ff_reg[j] <= 1'b0;
				pinN_reg[j] <= 1'b1;
				runPrev_reg[j] <= 1'b0;
				irq_reg[j] <= 1'b0;
			end else begin
				if (ctrlWr[j]) begin
					ctrl_reg[j] <= wdat;
				end
				if (dutyWr[j]) begin
					dutyHold_reg[j] <= wdat;
				end
				dutyAct_reg[j] <= dutyActNext[j];
				cnt_reg[j] <= cntNext[j];
				ff_reg[j] <= ffNext[j];
				pinN_reg[j] <= ~ffNext[j];
				runPrev_reg[j] <= running[j];
				irq_reg[j] <= ovf[j] | ((j == 1) & t16Match);
			end
		end
	end

	assign pwmOutLowN = pinN_reg[0];
	assign pwmOutHighN = pinN_reg[1];
	assign lowMatchIrq = irq_reg[0];
	assign upperMatchIrq = irq_reg[1];

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_pin_inverse: assert property (pinN_reg[0] == ~ff_reg[0] && pinN_reg[1] == ~ff_reg[1])
		else $error("pin is not the inverse of the flip-flop");
	a_reset_ff_clear: assert property (@(posedge core_clk) disable iff (1'b0)
		!rst_n |=> (ff_reg[0] == 1'b0 && ff_reg[1] == 1'b0 && pinN_reg[0]))
		else $error("flip-flop not cleared by reset");
	a_overflow_wraps: assert property (ovf[0] |=> cnt_reg[0] == 8'h00 && lowMatchIrq &&
		ff_reg[0] != $past(ff_reg[0]))
		else $error("overflow did not wrap, toggle and interrupt");
	a_match_keeps_count: assert property (dutyHit[0] && !ovf[0] && !ctrlWr[0] |=>
		cnt_reg[0] == $past(inc[0]) && ff_reg[0] != $past(ff_reg[0]) && !lowMatchIrq)
		else $error("duty match mishandled");
	a_shadow_transfer: assert property (ovf[0] |=> dutyAct_reg[0] == $past(dutyHold_reg[0]))
		else $error("held duty not transferred on interrupt");
	a_held_until_irq: assert property (dutyWr[0] && running[0] && !ovf[0] |=>
		$stable(dutyAct_reg[0]))
		else $error("running duty write took effect early");
	a_stopped_load: assert property (dutyWr[0] && !running[0] |=>
		dutyAct_reg[0] == $past(wdat))
		else $error("stopped duty write not immediate");
	a_stop_holds_pin: assert property (!running[0] && !ctrlWr[0] |=> $stable(pinN_reg[0]))
		else $error("pin moved while stopped");
	a_init_preset: assert property (ctrlWr[0] && !running[0] |=>
		ff_reg[0] == $past(wdat[pwm_timer_pkg::CTRL_INIT_BIT]))
		else $error("init bit not loaded into flip-flop");
	a_start_zero: assert property (pwmStart[0] || t16Start |=> cnt_reg[0] == 8'h00)
		else $error("start did not clear the counter");
	a_period_match: assert property (t16Match |=> cnt16 == 16'h0000 && upperMatchIrq)
		else $error("16-bit match mishandled");
	a_t16_source: assert property (t16Step |-> ctrl_reg[0][6] == 1'b0)
		else $error("16-bit timer stepped on a forbidden source");
	a_pwm_period: assert property (ovf[0] ##1 (!ctrlWr[0] && !pwmStart[0]) [*2]
		|-> cnt_reg[0] <= 8'h01)
		else $error("pwm counter left the wrap window");
	a_ack_single: assert property (wbAck |=> !wbAck)
		else $error("ack held for more than one cycle");
	a_period_immediate: assert property (busWrite && wbAdr == pwm_timer_pkg::OFF_PERIOD_LOW |=>
		periodLow_reg == $past(wdat))
		else $error("period byte not taken at once");
	a_irq_single: assert property (lowMatchIrq |=> !lowMatchIrq)
		else $error("match interrupt longer than one cycle");
	a_cascade_ff_quiet: assert property (cascade && !ctrlWr[1] |=> $stable(ff_reg[1]))
		else $error("upper flip-flop moved in 16-bit timer mode");
	a_cascade_irq_match: assert property (cascade && $past(cascade) && upperMatchIrq |->
		$past(t16Match))
		else $error("upper interrupt without a period match");
	a_count_held: assert property (!running[0] && !cascade |=> $stable(cnt_reg[0]))
		else $error("stopped counter moved");

endmodule // pwm_timer_pair

/* core/pwm_timer_pkg.sv */
// constants shared by the cascadable pwm timer pair
package pwm_timer_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] OFF_CTRL_LOW = 8'h00;
	localparam logic [7:0] OFF_CTRL_HIGH = 8'h04;
	localparam logic [7:0] OFF_DUTY_LOW = 8'h08;
	localparam logic [7:0] OFF_DUTY_HIGH = 8'h0C;
	localparam logic [7:0] OFF_PERIOD_LOW = 8'h10;
	localparam logic [7:0] OFF_PERIOD_HIGH = 8'h14;
	localparam logic [7:0] OFF_COUNT = 8'h18;
	localparam logic [7:0] OFF_CONFIG = 8'h1C;

	// ****************************************
	// channel control and config fields
	// ****************************************
	localparam int CTRL_INIT_BIT = 7;
	localparam int CTRL_CLK_LSB = 4;
	localparam int CTRL_RUN_BIT = 3;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CONFIG_PRESCALE_BIT = 0;
	localparam int CONFIG_SLOW_BIT = 1;

	localparam logic [2:0] MODE_TIMER8 = 3'h0;
	localparam logic [2:0] MODE_PWM8 = 3'h2;
	localparam logic [2:0] MODE_T16_LOW = 3'h3;
	localparam logic [2:0] MODE_T16_HIGH = 3'h4;

	// ****************************************
	// source clock select codes (tap index)
	// ****************************************
	localparam logic [2:0] CLK_DIV2048 = 3'h0;
	localparam logic [2:0] CLK_DIV128 = 3'h1;
	localparam logic [2:0] CLK_DIV32 = 3'h2;
	localparam logic [2:0] CLK_DIV8 = 3'h3;
	localparam logic [2:0] CLK_SUB = 3'h4;
	localparam logic [2:0] CLK_DIV2 = 3'h5;
	localparam logic [2:0] CLK_MAIN = 3'h6;

	localparam int DIV_BITS = 11;
	localparam int SUB_DIV_BITS = 3;

	// ****************************************
	// reset values and count limit
	// ****************************************
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] DUTY_RESET = 8'h00;
	localparam logic [7:0] PERIOD_RESET = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hFF;

endpackage

/* core/timer_prescaler.sv */
// prescaler producing one-cycle source-clock ticks for select codes 0 to 6
`timescale 1ns/100ps
module timer_prescaler (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic subClkIn,
	input wire logic prescalerSourceSelect,
	input wire logic slowMode,
	output logic [7:0] tapTick
);

	logic [pwm_timer_pkg::DIV_BITS-1:0] div_reg;
	logic [pwm_timer_pkg::SUB_DIV_BITS-1:0] subDiv_reg;
	logic subMeta_reg;
	logic subSync_reg;
	logic subPrev_reg;
	logic [7:0] tap_reg;
	wire logic subEdge;
	wire logic mainOk;
	wire logic subDiv8;
	wire logic [7:0] tapNext;

	// ****************************************
	// sub clock crossing
	// ****************************************
	always_ff @(posedge core_clk) begin
		subMeta_reg <= subClkIn;
		subSync_reg <= subMeta_reg;
		subPrev_reg <= subSync_reg;
	end

	assign subEdge = subSync_reg & ~subPrev_reg;
	assign subDiv8 = subEdge & (&subDiv_reg);
	// in slow modes the main oscillator is assumed stopped
	assign mainOk = ~slowMode;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			div_reg <= '0;
			subDiv_reg <= '0;
			tap_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 1'b1;
			subDiv_reg <= subEdge ? subDiv_reg + 1'b1 : subDiv_reg;
			tap_reg <= tapNext;
		end
	end

	assign tapNext[0] = (slowMode | prescalerSourceSelect) ? subDiv8 : (&div_reg);
	assign tapNext[1] = mainOk & (&div_reg[6:0]);
	assign tapNext[2] = mainOk & (&div_reg[4:0]);
	assign tapNext[3] = mainOk & (&div_reg[2:0]);
	assign tapNext[4] = subEdge;
	assign tapNext[5] = mainOk & div_reg[0];
	assign tapNext[6] = mainOk;
	assign tapNext[7] = 1'b0;
	assign tapTick = tap_reg;

endmodule // timer_prescaler

/* dv/pulse_monitor.sv */
// load model on a pulse pin: measures how long the pin stays high and low
`timescale 1ns/100ps
module pulse_monitor (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic pinN,
	output int highWidth,
	output int lowWidth
);
	int runLen;
	logic lastLevel;

	// ****************************************
	// phase width measurement
	// ****************************************
	// widths are in core clock cycles between two seen level changes
	always @(posedge core_clk) begin
		if (!rst_n) begin
			runLen <= 0;
			lastLevel <= 1'b1;
			highWidth <= 0;
			lowWidth <= 0;
		end else begin
			lastLevel <= pinN;
			if (pinN !== lastLevel) begin
				runLen <= 1;
				if (lastLevel)
					highWidth <= runLen;
				else
					lowWidth <= runLen;
			end else begin
				runLen <= runLen + 1;
			end
		end
	end
endmodule // pulse_monitor

/* dv/testbench.sv */
// self-checking bench for the cascadable pwm timer pair
`timescale 1ns/100ps
module testbench;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbWe = 1'b0;
	logic subClkIn = 1'b0;
	logic [7:0] wbAdr = 8'h00;
	logic [3:0] wbSel = 4'h0;
	logic [31:0] wbDatIn = 32'h0;
	logic [31:0] wbDatOut;
	logic wbAck;
	logic pwmOutLowN;
	logic pwmOutHighN;
	logic lowMatchIrq;
	logic upperMatchIrq;
	int highWidth;
	int lowWidth;
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;

	pwm_timer_pair pwm_timer_pair_i (.core_clk(core_clk), .rst_n(rst_n), .wbCyc(wbCyc),
		.wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
		.wbDatOut(wbDatOut), .wbAck(wbAck), .subClkIn(subClkIn), .pwmOutLowN(pwmOutLowN),
		.pwmOutHighN(pwmOutHighN), .lowMatchIrq(lowMatchIrq), .upperMatchIrq(upperMatchIrq));

	pulse_monitor pulse_monitor_i (.core_clk(core_clk), .rst_n(rst_n), .pinN(pwmOutLowN),
		.highWidth(highWidth), .lowWidth(lowWidth));

	// ****************************************
	// clocks, timeout, shared tasks
	// ****************************************
	initial begin
		forever #10 core_clk = ~core_clk;
	end

	// sub clock half period is 77 core cycles; it toggles on falling core edges only
	initial begin
		forever #1540 subClkIn = ~subClkIn;
	end

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// one classic wishbone cycle; ack and read data are taken at the same edge
	task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbSel <= 4'hF;
		wbDatIn <= {24'h0, d};
		do @(posedge core_clk); while (wbAck !== 1'b1);
		q = wbDatOut;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, adr, d, q);
	endtask

	task automatic rd_check(input logic [7:0] adr, input logic [31:0] exp, input string msg);
		logic [31:0] q;
		wb(1'b0, adr, 8'h00, q);
		check(q, exp, msg);
	endtask

	// counts core cycles up to the next irq pulse, bounded
	task automatic wait_irq(input logic upper, output int n);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while ((upper ? upperMatchIrq : lowMatchIrq) !== 1'b1 && n < 10000);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		check({pwmOutLowN, pwmOutHighN}, 2'b11, "pins after reset");
		check({lowMatchIrq, upperMatchIrq}, 2'b00, "irqs after reset");
		for (int a = 0; a <= 8'h20; a += 4)
			rd_check(a[7:0], 32'h0, "register after reset");
	endtask

	task automatic t_pwm();
		int n;
		wr(pwm_timer_pkg::OFF_DUTY_LOW, 8'h40);
		rd_check(pwm_timer_pkg::OFF_DUTY_LOW, 32'h40, "stopped duty load");
		wr(pwm_timer_pkg::OFF_CTRL_LOW, 8'h62);
		wr(pwm_timer_pkg::OFF_CTRL_LOW, 8'h6A);
		wait_irq(1'b0, n);
		wait_irq(1'b0, n);
		check(n, 256, "pwm period");
		wait_irq(1'b0, n);
		check(highWidth, 32'h40, "high phase equals duty");
		check(lowWidth, 192, "low phase after match");
		// new duty written right after the irq waits for the next one
		wr(pwm_timer_pkg::OFF_DUTY_LOW, 8'h80);
		rd_check(pwm_timer_pkg::OFF_DUTY_LOW, 32'h40, "old duty until irq");
		wait_irq(1'b0, n);
		rd_check(pwm_timer_pkg::OFF_DUTY_LOW, 32'h80, "duty shifted on irq");
		wait_irq(1'b0, n);
		check(highWidth, 32'h80, "new duty in effect");
	endtask

	task automatic t_stop();
		logic held;
		logic [31:0] c0;
		logic [31:0] c1;
		wr(pwm_timer_pkg::OFF_CTRL_LOW, 8'h62);
		@(posedge core_clk);
		held = pwmOutLowN;
		repeat (300) @(posedge core_clk);
		check(pwmOutLowN, held, "pin held when stopped");
		wb(1'b0, pwm_timer_pkg::OFF_COUNT, 8'h00, c0);
		wb(1'b0, pwm_timer_pkg::OFF_COUNT, 8'h00, c1);
		check(c1, c0, "count held when stopped");
		wr(pwm_timer_pkg::OFF_CTRL_LOW, 8'hE2);
		repeat (3) @(posedge core_clk);
		check(pwmOutLowN, 1'b0, "init bit one drives pin low");
		wr(pwm_timer_pkg::OFF_CTRL_LOW, 8'h62);
		repeat (3) @(posedge core_clk);
		check(pwmOutLowN, 1'b1, "init bit zero drives pin high");
		wr(pwm_timer_pkg::OFF_DUTY_LOW, 8'h30);
		rd_check(pwm_timer_pkg::OFF_DUTY_LOW, 32'h30, "stopped duty immediate");
	endtask

	// 16-bit interval on every cascade source: period 4 ticks of 2048/128/32/8
	task automatic t_cascade();
		int n;
		int tick[4] = '{2048, 128, 32, 8};
		wr(pwm_timer_pkg::OFF_PERIOD_LOW, 8'h04);
		wr(pwm_timer_pkg::OFF_PERIOD_HIGH, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(pwm_timer_pkg::OFF_CTRL_HIGH, 8'h04);
			wr(pwm_timer_pkg::OFF_CTRL_LOW, {1'b0, c[2:0], 4'h3});
			wr(pwm_timer_pkg::OFF_CTRL_HIGH, 8'h0C);
			wait_irq(1'b1, n);
			wait_irq(1'b1, n);
			check(n, 4 * tick[c], "cascade irq interval");
		end
		check(pwmOutHighN, 1'b1, "upper pin quiet in timer mode");
		// the sub clock tap is no legal cascade source, so no match may come
		wr(pwm_timer_pkg::OFF_CTRL_HIGH, 8'h04);
		wr(pwm_timer_pkg::OFF_CTRL_LOW, 8'h43);
		wr(pwm_timer_pkg::OFF_CTRL_HIGH, 8'h0C);
		wait_irq(1'b1, n);
		check(n, 10000, "no cascade step on sub clock");
		wr(pwm_timer_pkg::OFF_CTRL_HIGH, 8'h04);
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_pwm();
		t_stop();
		t_cascade();
		wrap_up();
	end
endmodule // testbench
